/* logic/lsd_defs.vh */
/*
  constants for the serial datapath: register map, field positions,
  reset values and timing counts. assumes inclusion by the datapath module.
*/
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LSD_OFF_CTRL     4'h0
`define LSD_OFF_TXDATA   4'h4
`define LSD_OFF_RXDATA   4'h8
`define LSD_OFF_STATUS   4'hC

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define LSD_CTRL_FACTOR_LSB  0
`define LSD_CTRL_FACTOR_MSB  3
`define LSD_CTRL_CLKMODE     4
`define LSD_CTRL_DIV_LSB     5
`define LSD_CTRL_DIV_MSB     8
`define LSD_CTRL_PHASE180    9
`define LSD_CTRL_BYPASS      10
`define LSD_CTRL_DDR         11
`define LSD_CTRL_DPA_EN      12
`define LSD_CTRL_PHASE_LSB   13
`define LSD_CTRL_PHASE_MSB   15
`define LSD_CTRL_ROLL_LSB    16
`define LSD_CTRL_ROLL_MSB    19
`define LSD_CTRL_FIFO_CLR    20
`define LSD_CTRL_SLIP        21
`define LSD_CTRL_RESET       32'h000B000A

// ----------------------------------------------------------------
// sizes and counts
// ----------------------------------------------------------------
`define LSD_WORD_MAX     10
`define LSD_FIFO_DEPTH   6
`define LSD_PHASES       8
`define LSD_SLIP_WAIT    2'h2
`define LSD_ROLL_MAX     11

`endif

/* logic/lsd_datapath.v */
/*
  serial transmit/receive datapath with an axi4-lite register slave.
  assumes aclk is the serial-rate clock; the parallel rate is an enable
  pulse every factor cycles. rx serial inputs come from pins and are
  synchronised; the eight pll phases arrive as a sampled bus.
*/
// Local design decisions: the address map and register access over AXI4-Lite.
// Operation
// RULE1: tx takes up to ten-bit word, loads, shifts
// RULE2: most significant bit leaves first
// RULE3: factor is 3,4,6,7,8 or 10
// RULE4: load strobe derived from factor
// RULE5: forwarded clock may toggle at data rate
// RULE6: forwarded clock divided by 1,2,4,6,8,10
// RULE7: clock phase selectable zero or 180 degrees
// RULE8: data channel may emit clock pattern
// RULE9: bypass gives factor two or one
// RULE10: sdr passes through, ddr uses two registers
// RULE11: receive fifo one bit by six
// RULE12: aligner picks one of pll phases
// RULE13: slip request inserts one bit latency
// RULE14: deserializer delivers up to ten bits
// RULE15: without alignment phase is static setting
// RULE16: aligned mode picks best phase automatically
// RULE17: core raises slip for one parallel cycle
// RULE18: rollover flag pulses one parallel cycle
// RULE19: realigned data valid two cycles after slip
// RULE20: clear input empties synchroniser fifo
// RULE21: one load strobe per factor cycles
// RULE22: bypass disables aligner and slip
`timescale 1ns/1ps
`include "lsd_defs.vh"

module lsd_datapath (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial link
  output reg         tx_serial,
  input  wire [7:0]  rx_phase_samples,
  input  wire        fifo_clear
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // legal factors only; anything else falls back to ten
  function [3:0] lsd_factor;
    input [3:0] f;
    begin
      case (f)
        4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hA: lsd_factor = f; // RULE3
        default: lsd_factor = 4'hA;
      endcase
    end
  endfunction

  // counter wrap test shared by tx, rx and clock divider
  function lsd_wrap;
    input [3:0] cnt;
    input [3:0] lim;
    begin
      lsd_wrap = (cnt >= lim - 4'h1);
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and bus slave
  // ----------------------------------------------------------------
  reg  [31:0] ctrl_reg;
  reg  [9:0]  txdata_reg;
  reg  [9:0]  rxdata_reg;
  reg         roll_reg;
  reg         roll_seen_reg;
  reg         aw_held_reg;
  reg         w_held_reg;
  reg  [3:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         tx_taken_reg;
  reg  [2:0]  phase_sel_reg;
  reg         dpa_locked_reg;

  wire [3:0] factor   = lsd_factor(ctrl_reg[`LSD_CTRL_FACTOR_MSB:`LSD_CTRL_FACTOR_LSB]);
  wire       clk_mode = ctrl_reg[`LSD_CTRL_CLKMODE];
  wire [3:0] clk_div  = ctrl_reg[`LSD_CTRL_DIV_MSB:`LSD_CTRL_DIV_LSB];
  wire       ph180    = ctrl_reg[`LSD_CTRL_PHASE180];
  wire       bypass   = ctrl_reg[`LSD_CTRL_BYPASS];
  wire       ddr_mode = ctrl_reg[`LSD_CTRL_DDR];
  wire       dpa_en   = ctrl_reg[`LSD_CTRL_DPA_EN] & ~bypass;            // RULE22
  wire [3:0] roll_pt  = ctrl_reg[`LSD_CTRL_ROLL_MSB:`LSD_CTRL_ROLL_LSB];
  wire       slip_in  = ctrl_reg[`LSD_CTRL_SLIP] & ~bypass;              // RULE22
  wire       fifo_clr_sw = ctrl_reg[`LSD_CTRL_FIFO_CLR];
  // phase in use: automatic pick, or the static setting without alignment
  wire [2:0] phase_now = dpa_en ? phase_sel_reg
                                : ctrl_reg[`LSD_CTRL_PHASE_MSB:`LSD_CTRL_PHASE_LSB]; // RULE15

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire aw_go  = s_axi_awvalid & s_axi_awready;
  wire w_go   = s_axi_wvalid & s_axi_wready;
  wire aw_ok  = aw_held_reg | aw_go;
  wire w_ok   = w_held_reg | w_go;
  wire [3:0]  wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire        wr_fire = aw_ok & w_ok & ~s_axi_bvalid;
  wire        wr_map  = (wr_addr == `LSD_OFF_CTRL) | (wr_addr == `LSD_OFF_TXDATA);
  wire        tx_load;
  wire        rd_fire = s_axi_arvalid & s_axi_arready;

  // byte-lane merge of a write into a word
  function [31:0] lsd_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer i;
    begin
      lsd_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          lsd_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // merged transmit word; only the low ten bits are kept
  wire [31:0] tx_merged = lsd_merge({22'h000000, txdata_reg}, wr_data, wr_strb);

  // write channel: address and data accepted in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 4'h0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_reg    <= `LSD_CTRL_RESET;
      txdata_reg  <= 10'h000;
      tx_taken_reg <= 1'b1;
    end else begin
      if (aw_go) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_go) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (tx_load)
        tx_taken_reg <= 1'b1;
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
        if (wr_addr == `LSD_OFF_CTRL)
          ctrl_reg <= lsd_merge(ctrl_reg, wr_data, wr_strb);
        if (wr_addr == `LSD_OFF_TXDATA) begin
          txdata_reg   <= tx_merged[9:0];                             // RULE1
          tx_taken_reg <= 1'b0;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `LSD_OFF_CTRL:   s_axi_rdata <= ctrl_reg;
        `LSD_OFF_TXDATA: s_axi_rdata <= {22'h000000, txdata_reg};
        `LSD_OFF_RXDATA: s_axi_rdata <= {22'h000000, rxdata_reg};
        `LSD_OFF_STATUS: s_axi_rdata <= {26'h0000000, phase_now, dpa_locked_reg,
                                         roll_seen_reg, tx_taken_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  reg [3:0] tx_cnt_reg;
  reg [9:0] tx_load_reg;
  reg [9:0] tx_shift_reg;
  reg [3:0] fclk_cnt_reg;
  reg       fclk_reg;
  reg       ddr_phase_reg;
  reg [1:0] ddr_out_reg;

  // one strobe every factor serial cycles
  assign tx_load = lsd_wrap(tx_cnt_reg, factor);                     // RULE21 RULE4

  // load register, shift register and forwarded clock divider
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_cnt_reg    <= 4'h0;
      tx_load_reg   <= 10'h000;
      tx_shift_reg  <= 10'h000;
      fclk_cnt_reg  <= 4'h0;
      fclk_reg      <= 1'b0;
      ddr_phase_reg <= 1'b0;
      ddr_out_reg   <= 2'h0;
    end else begin
      tx_cnt_reg  <= tx_load ? 4'h0 : tx_cnt_reg + 4'h1;
      tx_load_reg <= txdata_reg;                                      // RULE1
      if (tx_load)
        tx_shift_reg <= tx_load_reg << (4'hA - factor);               // RULE1
      else
        tx_shift_reg <= {tx_shift_reg[8:0], 1'b0};                    // RULE2
      // divide by one toggles every cycle: clock at data rate
      if (clk_div <= 4'h1) begin
        fclk_reg <= ~fclk_reg;                                        // RULE5
        fclk_cnt_reg <= 4'h0;
      end else if (tx_load) begin
        fclk_cnt_reg <= 4'h0;
        fclk_reg <= 1'b1;
      end else if (lsd_wrap(fclk_cnt_reg, clk_div >> 1)) begin
        fclk_cnt_reg <= 4'h0;
        fclk_reg <= ~fclk_reg;                                        // RULE6
      end else begin
        fclk_cnt_reg <= fclk_cnt_reg + 4'h1;
      end
      // ddr bypass: two output registers, one bit each half
      ddr_phase_reg <= ~ddr_phase_reg;
      if (!ddr_phase_reg)
        ddr_out_reg <= txdata_reg[1:0];                               // RULE10
    end
  end

  // output select: clock pattern, bypass or serial data
  always @(posedge aclk) begin
    if (!aresetn)
      tx_serial <= 1'b0;
    else if (clk_mode)
      tx_serial <= fclk_reg ^ ph180;                                  // RULE8 RULE7
    else if (bypass && !ddr_mode)
      tx_serial <= txdata_reg[0];                                     // RULE9 RULE10
    else if (bypass)
      tx_serial <= ddr_phase_reg ? ddr_out_reg[0] : ddr_out_reg[1];   // RULE9
    else
      tx_serial <= tx_shift_reg[9];                                   // RULE2
  end

  // ----------------------------------------------------------------
  // receiver: phase pick, fifo, slip, deserializer
  // ----------------------------------------------------------------
  reg [7:0] ph_s1_reg;
  reg [7:0] ph_s2_reg;
  reg [7:0] ph_prev_reg;
  reg       fclr_s1_reg;
  reg       fclr_s2_reg;
  reg [5:0] fifo_reg;
  reg [2:0] fifo_cnt_reg;
  reg [10:0] slip_dly_reg;
  reg [3:0] slip_amt_reg;
  reg       slip_prev_reg;
  reg [3:0] rx_cnt_reg;
  reg [9:0] rx_shift_reg;
  reg [1:0] slip_wait_reg;
  reg       rx_bit;
  reg       slip_bit;
  integer   k;

  wire fifo_clr = fclr_s2_reg | fifo_clr_sw;
  wire par_en   = lsd_wrap(rx_cnt_reg, factor);
  wire sel_bit  = ph_s2_reg[phase_now];                               // RULE12 RULE15

  // fifo output and slip tap
  always @* begin
    rx_bit = (fifo_cnt_reg == 3'h0) ? sel_bit : fifo_reg[fifo_cnt_reg - 3'h1];
    slip_bit = (slip_amt_reg == 4'h0) ? rx_bit : slip_dly_reg[slip_amt_reg - 4'h1];
  end

  // pins pass two flops; phase chosen where no neighbour shows a transition
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph_s1_reg      <= 8'h00;
      ph_s2_reg      <= 8'h00;
      ph_prev_reg    <= 8'h00;
      phase_sel_reg  <= 3'h0;
      dpa_locked_reg <= 1'b0;
      fclr_s1_reg    <= 1'b0;
      fclr_s2_reg    <= 1'b0;
    end else begin
      ph_s1_reg   <= rx_phase_samples;
      ph_s2_reg   <= ph_s1_reg;
      ph_prev_reg <= ph_s2_reg;
      // clear pin comes from outside: two flops before use
      fclr_s1_reg <= fifo_clear;
      fclr_s2_reg <= fclr_s1_reg;
      // last and first phase belong to different bit times: no wrap compare
      if (dpa_en) begin
        for (k = 0; k < `LSD_PHASES - 1; k = k + 1)
          if (ph_s2_reg[k] != ph_s2_reg[k + 1] &&
              ph_s2_reg != ph_prev_reg) begin
            phase_sel_reg  <= k[2:0] + 3'h5;                          // RULE16
            dpa_locked_reg <= 1'b1;
          end
      end
    end
  end

  // synchroniser fifo, slip delay line and deserializer
  always @(posedge aclk) begin
    if (!aresetn) begin
      fifo_reg      <= 6'h00;
      fifo_cnt_reg  <= 3'h0;
      slip_dly_reg  <= 11'h000;
      slip_amt_reg  <= 4'h0;
      slip_prev_reg <= 1'b0;
      slip_wait_reg <= 2'h0;
      rx_cnt_reg    <= 4'h0;
      rx_shift_reg  <= 10'h000;
      rxdata_reg    <= 10'h000;
      roll_reg      <= 1'b0;
      roll_seen_reg <= 1'b0;
    end else begin
      if (fifo_clr) begin
        fifo_reg     <= 6'h00;                                        // RULE20
        fifo_cnt_reg <= 3'h0;
      end else if (dpa_en) begin
        fifo_reg <= {fifo_reg[4:0], sel_bit};                         // RULE11
        if (fifo_cnt_reg < 3'h3)
          fifo_cnt_reg <= fifo_cnt_reg + 3'h1;
      end
      slip_dly_reg <= {slip_dly_reg[9:0], rx_bit};
      rx_cnt_reg   <= par_en ? 4'h0 : rx_cnt_reg + 4'h1;
      rx_shift_reg <= {rx_shift_reg[8:0], slip_bit};                  // RULE14
      if (par_en) begin
        slip_prev_reg <= slip_in;
        roll_reg      <= 1'b0;
        if (slip_wait_reg != 2'h0)
          slip_wait_reg <= slip_wait_reg - 2'h1;                      // RULE19
        if (slip_in && !slip_prev_reg) begin                          // RULE17
          slip_wait_reg <= `LSD_SLIP_WAIT;
          if (slip_amt_reg + 4'h1 >= roll_pt) begin
            slip_amt_reg <= 4'h0;
            roll_reg     <= 1'b1;                                     // RULE18
          end else begin
            slip_amt_reg <= slip_amt_reg + 4'h1;                      // RULE13
          end
        end
        rxdata_reg <= bypass ? {8'h00, rx_shift_reg[1:0] & (ddr_mode ? 2'h3 : 2'h1)}
                             : rx_shift_reg & ((10'h001 << factor) - 10'h001); // RULE22 RULE14
      end
      if (roll_reg)
        roll_seen_reg <= 1'b1;
      if (rd_fire && s_axi_araddr == `LSD_OFF_STATUS && !roll_reg)
        roll_seen_reg <= 1'b0;
    end
  end

endmodule // lsd_datapath

/* verif/lsd_far_end.sv */
/*
  far-end serial source: repeats a word msb first, one bit per cycle,
  as seen by eight sampling phases. assumes aclk is the serial rate.
*/
`timescale 1ns/1ps
module lsd_far_end (
  // clock
  input  wire       aclk,
  // stream setup
  input  wire [9:0] word,
  input  wire [3:0] factor,
  input  wire [2:0] skew,
  // sampled line
  output reg  [7:0] rx_phase_samples
);
  reg  [3:0] idx  = 4'h0;
  reg        prev = 1'b0;
  integer    p;

  // phases below the skew point still see the previous bit
  always @(posedge aclk) begin
    idx  <= (idx + 4'h1 >= factor) ? 4'h0 : idx + 4'h1;
    prev <= word[factor - 4'h1 - idx];
    for (p = 0; p < 8; p = p + 1)
      rx_phase_samples[p] <= (p < skew) ? prev : word[factor - 4'h1 - idx];
  end
endmodule // lsd_far_end

/* verif/lsd_checker_assertions.sv */
/*
  bus handshake and reset checks on the datapath ports.
  assumes one clock, aclk, and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
module lsd_checker (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write side
  input  wire        s_axi_awvalid,
  input  wire        s_axi_awready,
  input  wire        s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // read side
  input  wire        s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial
  input  wire        tx_serial
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // reset must hold every answer and the line low
  property p_reset_quiet;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !tx_serial;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2];
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_w_block: assert property (p_w_block) else $error("write taken while answering");
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  a_w_answer: assert property (p_w_answer) else $error("write answer late");
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  a_b_once: assert property (p_b_once) else $error("write answered twice");

  // main scenarios reached
  c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_tx_edge: cover property ($rose(tx_serial));
endmodule // lsd_checker

bind lsd_datapath lsd_checker i_lsd_checker (.*);

/* verif/lsd_datapath_tb.sv */
/*
  self-checking bench: bus tasks, tx pattern search, rx slip and phase
  checks via the far-end model. assumes the checker is bound.
*/
`timescale 1ns/1ps
module lsd_datapath_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, fifo_clear;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, far_factor;
  reg  [9:0]  far_word, w;
  reg  [2:0]  far_skew;
  reg  [23:0] fac_tab;
  reg  [31:0] s_axi_wdata, rd_last, seed_v;
  reg  [63:0] exp_q[$], ent;
  reg  [1:0]  bq[$];
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, tx_serial;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  rx_phase_samples;
  integer     errors, n_tests, cyc, i, k0;

  always #25 aclk = ~aclk;
  lsd_datapath i_lsd_datapath (.*);
  lsd_far_end i_lsd_far_end (.aclk(aclk), .word(far_word), .factor(far_factor),
    .skew(far_skew), .rx_phase_samples(rx_phase_samples));

  task check(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // answers are compared against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rd_last = s_axi_rdata;
      ent = exp_q.pop_front();
      check(s_axi_rdata & ent[63:32], ent[31:0]);
    end
    if (s_axi_bvalid && s_axi_bready)
      check({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      wrap_up;
    end
  end

  task wr(input [3:0] a, input [31:0] d, input [1:0] er);
    begin
      bq.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // extra edge at the end lets the monitor record the data first
  task rd(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      exp_q.push_back({m, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // the line phase is unknown, so search every rotation of the word
  task tx_chk(input [3:0] f, input [9:0] v);
    reg [19:0] s;
    integer j, k, hit, ok, per;
    begin
      repeat (3 * f + 4) @(posedge aclk);
      for (j = 0; j < 2 * f; j = j + 1) begin
        @(negedge aclk);
        s[j] = tx_serial;
      end
      hit = 0;
      per = 1;
      for (k = 0; k < f; k = k + 1) begin
        ok = 1;
        for (j = 0; j < f; j = j + 1)
          if (s[k + j] !== v[f - 1 - j]) ok = 0;
        if (s[k] !== s[k + f]) per = 0;
        if (ok) hit = 1;
      end
      check(hit, 1);
      check(per, 1);
      @(posedge aclk);
    end
  endtask

  function integer rot_of(input [3:0] v);
    integer k;
    reg [3:0] x;
    begin
      rot_of = -1;
      x = 4'h8;
      for (k = 0; k < 4; k = k + 1) begin
        if (v === x) rot_of = k;
        x = {x[0], x[3:1]};
      end
    end
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, fifo_clear} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    far_word = 10'h008;
    far_factor = 4'h4;
    far_skew = 3'h2;
    fac_tab = 24'hA87643;
    {errors, n_tests, cyc} = 96'h0;
    seed_v = $urandom(61);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0, 32'hFFFFFFFF, 32'h000B000A);
    wr(4'h8, 32'h0, 2'h2);
    $display("test registers done");
    for (i = 0; i < 6; i = i + 1) begin
      w = $urandom;
      wr(4'h0, {28'h000B000, fac_tab[4 * i +: 4]}, 2'h0);
      wr(4'h4, {22'h0, w}, 2'h0);
      rd(4'h4, 32'h3FF, {22'h0, w});
      tx_chk(fac_tab[4 * i +: 4], w);
    end
    $display("test serializer done");
    wr(4'h0, 32'h000B040A, 2'h0);
    tx_chk(4'h1, w);
    wr(4'h0, 32'h000B0C0A, 2'h0);
    tx_chk(4'h2, w);
    $display("test bypass done");
    wr(4'h0, 32'h000B0034, 2'h0);
    tx_chk(4'h2, 10'h002);
    wr(4'h0, 32'h000B0294, 2'h0);
    tx_chk(4'h4, 10'h00C);
    $display("test clock output done");
    wr(4'h0, 32'h0004A004, 2'h0);
    repeat (60) @(posedge aclk);
    rd(4'hC, 32'h38, 32'h28);
    rd(4'h8, 32'h0, 32'h0);
    k0 = rot_of(rd_last[3:0]);
    check(k0 >= 0, 1);
    for (i = 1; i < 5; i = i + 1) begin
      wr(4'h0, 32'h0024A004, 2'h0);
      repeat (8) @(posedge aclk);
      wr(4'h0, 32'h0004A004, 2'h0);
      repeat (16) @(posedge aclk);
      rd(4'h8, 32'h0, 32'h0);
      check(rot_of(rd_last[3:0]), (k0 + i) % 4);
    end
    rd(4'hC, 32'h2, 32'h2);
    rd(4'hC, 32'h2, 32'h0);
    fifo_clear <= 1'b1;
    repeat (8) @(posedge aclk);
    fifo_clear <= 1'b0;
    repeat (40) @(posedge aclk);
    rd(4'h8, 32'h0, 32'h0);
    check(rot_of(rd_last[3:0]) >= 0, 1);
    $display("test receiver done");
    far_skew <= 3'h1 + $urandom % 7;
    wr(4'h0, 32'h00041004, 2'h0);
    repeat (60) @(posedge aclk);
    rd(4'hC, 32'h3C, {26'h0, far_skew + 3'h4, 3'h4});
    $display("test phase select done");
    wrap_up;
  end
endmodule // lsd_datapath_tb
